// file: upc_map.svh
// upc_map.svh: counts, widths and field positions of the uncore counter array.
// Included by upc_box and the array top; definitions only.
//
// Behaviour
// - An occupancy event is counted only on counter 0 of a caching-agent box, never on counter 1.
// - Any other caching-agent event may be counted on any of the four counters, 0 to 3.
// - Caching-agent events describe core-initiated transactions, such as data source and snoop result.
// - Uncore counts carry no qualification by hardware thread.
// - Each caching agent and the power controller unit holds its own independent counter group.
// - Up to eight caching-agent boxes exist, each with its own counter group.
// - A caching-agent box has four 44-bit counters behind a per-box enable and no sub-control.
// - The utility box has two 44-bit counters with no per-box enable, gated by the shared uncore enable.
// - With freeze-on-overflow set, any enabled counter overflow clears the uncore enable.
// - A counter advances only while the enable bit of its event select is set.
`ifndef UPC_MAP_SVH
`define UPC_MAP_SVH

`define UPC_NUM_CBOX     8
`define UPC_CBOX_NCTR    4
`define UPC_CBOX_WIDTH   44
`define UPC_PCU_NCTR     4
`define UPC_PCU_WIDTH    48
`define UPC_UBOX_NCTR    2
`define UPC_UBOX_WIDTH   44
`define UPC_OCC_CTR      0
`define UPC_EVT_W        8
`define UPC_GLB_EN_RST   1'b0

`endif

// file: upc_pkg.sv
// upc_pkg: types shared by the uncore counter array.
// Assumes nothing of its surroundings.
`default_nettype none
package upc_pkg;
  typedef enum logic [1:0]
  {
    UPC_KIND_CBOX,
    UPC_KIND_PCU,
    UPC_KIND_UBOX
  } upc_box_kind_t;
endpackage : upc_pkg
`default_nettype wire

// file: upc_box_if.sv
// upc_box_if: control, events and counts between the array top and one box.
// Assumes the top drives every ctl-side signal on mclk.
`default_nettype none
interface upc_box_if #(
  parameter int NCTR  = 4,
  parameter int WIDTH = 44,
  parameter int EVW   = 8
);
  logic             box_en;
  logic             ctr_en [NCTR];
  logic             occ    [NCTR];
  logic             evt    [NCTR];
  logic             clr    [NCTR];
  logic [EVW-1:0]   code   [NCTR];
  logic [EVW-1:0]   match;
  logic [EVW-1:0]   mask;
  logic [WIDTH-1:0] count  [NCTR];
  logic             ovf;

  modport box (input box_en, ctr_en, occ, evt, clr, code, match, mask,
               output count, ovf);
  modport ctl (output box_en, ctr_en, occ, evt, clr, code, match, mask,
               input count, ovf);
endinterface : upc_box_if
`default_nettype wire

// file: upc_box.sv
// upc_box: one local counter group with its own qualification and overflow flag.
// Assumes events and controls are synchronous to mclk.
`default_nettype none
`include "upc_map.svh"
module upc_box
  import upc_pkg::*;
#(
  parameter upc_box_kind_t KIND  = UPC_KIND_CBOX,
  parameter int            NCTR  = 4,
  parameter int            WIDTH = 44,
  parameter int            EVW   = 8
)
(
  input  wire logic mclk,
  input  wire logic resetn,
  upc_box_if.box    bif
);

  logic inc  [NCTR];
  logic wrap [NCTR];
  logic any_wrap;

  function automatic logic qualifies(input logic           evt,
                                     input logic           occ,
                                     input int             idx,
                                     input logic [EVW-1:0] code,
                                     input logic [EVW-1:0] match,
                                     input logic [EVW-1:0] mask);
    logic ok;
    ok = evt;
    if (KIND == UPC_KIND_CBOX && occ && idx != `UPC_OCC_CTR)
      ok = 1'b0;
    if (KIND == UPC_KIND_PCU && ((code ^ match) & mask) != '0)
      ok = 1'b0;
    return ok;
  endfunction : qualifies

  genvar j;
  generate
    for (j = 0; j < NCTR; j++)
    begin : g_ctr
      assign inc[j]  = bif.box_en && bif.ctr_en[j] &&
                       qualifies(bif.evt[j], bif.occ[j], j, bif.code[j], bif.match, bif.mask);
      // a clear in the same cycle wins, so no overflow is flagged then
      assign wrap[j] = inc[j] && !bif.clr[j] && (&bif.count[j]);

      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
          bif.count[j] <= '0;
        else if (bif.clr[j])
          bif.count[j] <= '0;
        else if (inc[j])
          bif.count[j] <= bif.count[j] + WIDTH'(1);
      end
    end
  endgenerate

  always_comb
  begin
    any_wrap = 1'b0;
    for (int k = 0; k < NCTR; k++)
      any_wrap = any_wrap | wrap[k];
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      bif.ovf <= 1'b0;
    else
      bif.ovf <= any_wrap;
  end

endmodule : upc_box
`default_nettype wire

// file: upc_counter_array.sv
// upc_counter_array: caching-agent, power-controller and utility counter boxes
// with the shared uncore enable and freeze-on-overflow.
// Assumes all inputs come from logic on mclk; control bits arrive as plain ports.
`default_nettype none
`include "upc_map.svh"
module upc_counter_array
  import upc_pkg::*;
#(
  parameter int NCBOX = `UPC_NUM_CBOX,
  parameter int CN    = `UPC_CBOX_NCTR,
  parameter int CW    = `UPC_CBOX_WIDTH,
  parameter int PN    = `UPC_PCU_NCTR,
  parameter int PW    = `UPC_PCU_WIDTH,
  parameter int UN    = `UPC_UBOX_NCTR,
  parameter int UW    = `UPC_UBOX_WIDTH,
  parameter int EVW   = `UPC_EVT_W
)
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // shared uncore enable
  input  wire logic                  glb_en_set,
  input  wire logic                  glb_en_clr,
  input  wire logic                  freeze_on_ovf,
  output var  logic                  glb_en,
  // caching-agent boxes
  input  wire logic [NCBOX-1:0]      cbox_box_en,
  input  wire logic [NCBOX*CN-1:0]   cbox_ctr_en,
  input  wire logic [NCBOX*CN-1:0]   cbox_occ,
  input  wire logic [NCBOX*CN-1:0]   cbox_evt,
  input  wire logic [NCBOX*CN-1:0]   cbox_clr,
  output wire logic [NCBOX*CN*CW-1:0] cbox_count,
  output wire logic [NCBOX-1:0]      cbox_ovf,
  // power controller unit box
  input  wire logic                  pcu_box_en,
  input  wire logic [PN-1:0]         pcu_ctr_en,
  input  wire logic [PN-1:0]         pcu_evt,
  input  wire logic [PN*EVW-1:0]     pcu_code,
  input  wire logic [EVW-1:0]        pcu_match,
  input  wire logic [EVW-1:0]        pcu_mask,
  input  wire logic [PN-1:0]         pcu_clr,
  output wire logic [PN*PW-1:0]      pcu_count,
  output wire logic                  pcu_ovf,
  // utility box
  input  wire logic [UN-1:0]         ubox_ctr_en,
  input  wire logic [UN-1:0]         ubox_evt,
  input  wire logic [UN-1:0]         ubox_clr,
  output wire logic [UN*UW-1:0]      ubox_count,
  output wire logic                  ubox_ovf
);

  logic any_ovf;

  // no thread id enters any box
  genvar i, j;
  generate
    for (i = 0; i < NCBOX; i++)
    begin : g_cbox
      upc_box_if #(.NCTR(CN), .WIDTH(CW), .EVW(EVW)) bif ();

      assign bif.box_en = cbox_box_en[i] && glb_en;
      assign bif.match  = '0;
      assign bif.mask   = '0;
      for (j = 0; j < CN; j++)
      begin : g_ctr
        assign bif.ctr_en[j] = cbox_ctr_en[i*CN+j];
        assign bif.occ[j]    = cbox_occ[i*CN+j];
        assign bif.evt[j]    = cbox_evt[i*CN+j];
        assign bif.clr[j]    = cbox_clr[i*CN+j];
        assign bif.code[j]   = '0;
        assign cbox_count[(i*CN+j)*CW +: CW] = bif.count[j];
      end
      assign cbox_ovf[i] = bif.ovf;

      upc_box #(.KIND(UPC_KIND_CBOX), .NCTR(CN), .WIDTH(CW), .EVW(EVW)) u_box
      (
        .mclk   (mclk),
        .resetn (resetn),
        .bif    (bif)
      );
    end
  endgenerate

  upc_box_if #(.NCTR(PN), .WIDTH(PW), .EVW(EVW)) pcu_if ();

  assign pcu_if.box_en = pcu_box_en && glb_en;
  assign pcu_if.match  = pcu_match;
  assign pcu_if.mask   = pcu_mask;
  generate
    for (j = 0; j < PN; j++)
    begin : g_pcu
      assign pcu_if.ctr_en[j] = pcu_ctr_en[j];
      assign pcu_if.occ[j]    = 1'b0;
      assign pcu_if.evt[j]    = pcu_evt[j];
      assign pcu_if.clr[j]    = pcu_clr[j];
      assign pcu_if.code[j]   = pcu_code[j*EVW +: EVW];
      assign pcu_count[j*PW +: PW] = pcu_if.count[j];
    end
  endgenerate
  assign pcu_ovf = pcu_if.ovf;

  upc_box #(.KIND(UPC_KIND_PCU), .NCTR(PN), .WIDTH(PW), .EVW(EVW)) u_pcu
  (
    .mclk   (mclk),
    .resetn (resetn),
    .bif    (pcu_if)
  );

  upc_box_if #(.NCTR(UN), .WIDTH(UW), .EVW(EVW)) ubox_if ();

  assign ubox_if.box_en = glb_en;
  assign ubox_if.match  = '0;
  assign ubox_if.mask   = '0;
  generate
    for (j = 0; j < UN; j++)
    begin : g_ubox
      assign ubox_if.ctr_en[j] = ubox_ctr_en[j];
      assign ubox_if.occ[j]    = 1'b0;
      assign ubox_if.evt[j]    = ubox_evt[j];
      assign ubox_if.clr[j]    = ubox_clr[j];
      assign ubox_if.code[j]   = '0;
      assign ubox_count[j*UW +: UW] = ubox_if.count[j];
    end
  endgenerate
  assign ubox_ovf = ubox_if.ovf;

  upc_box #(.KIND(UPC_KIND_UBOX), .NCTR(UN), .WIDTH(UW), .EVW(EVW)) u_ubox
  (
    .mclk   (mclk),
    .resetn (resetn),
    .bif    (ubox_if)
  );

  assign any_ovf = (|cbox_ovf) | pcu_ovf | ubox_ovf;

  // freeze beats a same-cycle set so counts stay consistent
  // overflow freezes uncore enable
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      glb_en <= `UPC_GLB_EN_RST;
    else if (freeze_on_ovf && any_ovf)
      glb_en <= 1'b0;
    else if (glb_en_set)
      glb_en <= 1'b1;
    else if (glb_en_clr)
      glb_en <= 1'b0;
  end

endmodule : upc_counter_array
`default_nettype wire

// file: upc_counter_array_props.sv
// upc_props: assertions on the counter array ports, box 0 counters 0 and 1.
// Assumes one mclk domain and resetn low while resetting.
`default_nettype none
module upc_props #(
  parameter int NCBOX = 8,
  parameter int CN    = 4,
  parameter int CW    = 44
)
(
  input wire logic                   mclk,
  input wire logic                   resetn,
  input wire logic                   freeze_on_ovf,
  input wire logic                   glb_en,
  input wire logic [NCBOX-1:0]       cbox_box_en,
  input wire logic [NCBOX*CN-1:0]    cbox_ctr_en,
  input wire logic [NCBOX*CN-1:0]    cbox_occ,
  input wire logic [NCBOX*CN-1:0]    cbox_evt,
  input wire logic [NCBOX*CN-1:0]    cbox_clr,
  input wire logic [NCBOX*CN*CW-1:0] cbox_count,
  input wire logic [NCBOX-1:0]       cbox_ovf,
  input wire logic                   pcu_ovf,
  input wire logic                   ubox_ovf
);
  logic [CW-1:0] c0;
  logic [CW-1:0] c1;
  logic          inc0;
  assign c0 = cbox_count[0 +: CW];
  assign c1 = cbox_count[CW +: CW];
  assign inc0 = glb_en && cbox_box_en[0] && cbox_ctr_en[0] && cbox_evt[0] && !cbox_clr[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_occ_ctr1_idle: assert property (cbox_occ[1] && !cbox_clr[1] |=> $stable(c1))
    else $error("occupancy event moved counter 1");
  a_inc_by_one: assert property (inc0 |=> c0 == CW'($past(c0) + 1'b1))
    else $error("counter 0 did not step by one");
  a_ctr_en_gate: assert property (!cbox_ctr_en[0] && !cbox_clr[0] |=> $stable(c0))
    else $error("counter 0 moved while its enable was low");
  a_box_en_gate: assert property (!cbox_box_en[0] && !cbox_clr[0] |=> $stable(c0))
    else $error("counter 0 moved while its box was disabled");
  a_frozen_idle: assert property (!glb_en && !cbox_clr[0] |=> $stable(c0))
    else $error("counter 0 moved while uncore enable was low");
  a_clear_zero: assert property (cbox_clr[0] |=> c0 == '0)
    else $error("counter 0 not zero after clear");
  a_wrap_ovf: assert property (inc0 && (&c0) |=> c0 == '0 && cbox_ovf[0])
    else $error("wrap did not give zero with overflow pulse");
  a_ovf_freeze: assert property (freeze_on_ovf && (|{cbox_ovf, pcu_ovf, ubox_ovf}) |=> !glb_en)
    else $error("overflow with freeze left uncore enable set");
endmodule : upc_props
bind upc_counter_array upc_props #(.NCBOX(NCBOX), .CN(CN), .CW(CW)) u_props (.*);
`default_nettype wire

// file: testbench.sv
// testbench: directed scenarios for the counter array with short counters.
// Assumes upc_pkg, upc_box_if, upc_box and the array top are compiled first.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // short widths so a wrap takes a few cycles
  localparam int NB = 2;
  localparam int CW = 4;
  localparam int PW = 5;
  logic mclk, resetn, glb_en_set, glb_en_clr, freeze_on_ovf, glb_en;
  logic pcu_box_en, pcu_ovf, ubox_ovf;
  logic [NB-1:0]      cbox_box_en, cbox_ovf;
  logic [7:0]         cbox_ctr_en, cbox_occ, cbox_evt, cbox_clr, pcu_match, pcu_mask;
  logic [NB*4*CW-1:0] cbox_count;
  logic [3:0]         pcu_ctr_en, pcu_evt, pcu_clr;
  logic [31:0]        pcu_code;
  logic [4*PW-1:0]    pcu_count;
  logic [1:0]         ubox_ctr_en, ubox_evt, ubox_clr;
  logic [7:0]         ubox_count;
  int                 fail_count, n_checks;
  upc_counter_array #(.NCBOX(NB), .CW(CW), .PW(PW), .UW(4)) DUT (.*);
  always #20 mclk = ~mclk;
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  function automatic logic [CW-1:0] cc(input int k);
    return cbox_count[k*CW +: CW];
  endfunction : cc
  task automatic cev(input logic [7:0] m, input int n);
    cbox_evt = m;
    tick(n);
    cbox_evt = 8'h00;
  endtask : cev
  task automatic go;
    glb_en_set = 1'b1;
    tick(1);
    glb_en_set = 1'b0;
  endtask : go
  task automatic s_gate;
    `CHK("reset count", 32'h0000_0000, cbox_count)
    go;
    cbox_box_en = 2'h1;
    cev(8'h01, 3);
    `CHK("ctr_en off", 4'h0, cc(0))
    cbox_ctr_en = 8'h01;
    cev(8'h01, 3);
    `CHK("three events", 4'h3, cc(0))
    cbox_box_en = 2'h0;
    cev(8'h01, 2);
    `CHK("box off", 4'h3, cc(0))
  endtask : s_gate
  task automatic s_occ;
    cbox_box_en = 2'h3;
    cbox_ctr_en = 8'h33;
    cbox_clr = 8'hff;
    tick(1);
    cbox_clr = 8'h00;
    cbox_occ = 8'h03;
    cev(8'h03, 4);
    `CHK("occ ctr0", 4'h4, cc(0))
    `CHK("occ ctr1", 4'h0, cc(1))
    cbox_occ = 8'h00;
    cev(8'h02, 2);
    `CHK("plain ctr1", 4'h2, cc(1))
    cev(8'h10, 1);
    `CHK("box1 ctr0", 4'h1, cc(4))
    `CHK("box0 ctr0", 4'h4, cc(0))
  endtask : s_occ
  task automatic s_pcu;
    pcu_box_en = 1'b1;
    pcu_ctr_en = 4'h3;
    pcu_code = 32'h0000_3c5a;
    pcu_match = 8'h5a;
    pcu_mask = 8'hf0;
    pcu_evt = 4'h3;
    tick(2);
    pcu_mask = 8'h00;
    tick(1);
    pcu_evt = 4'h1;
    `CHK("pcu ctr0", 5'h03, pcu_count[0 +: PW])
    `CHK("pcu ctr1", 5'h01, pcu_count[PW +: PW])
    tick(29);
    pcu_evt = 4'h0;
    `CHK("pcu wrap", 5'h00, pcu_count[0 +: PW])
    `CHK("pcu ovf", 1'b1, pcu_ovf)
  endtask : s_pcu
  task automatic s_ubox;
    cbox_box_en = 2'h0;
    pcu_box_en = 1'b0;
    ubox_ctr_en = 2'h3;
    ubox_evt = 2'h2;
    tick(2);
    `CHK("ubox no box en", 8'h20, ubox_count)
    glb_en_clr = 1'b1;
    tick(1);
    glb_en_clr = 1'b0;
    tick(2);
    ubox_evt = 2'h0;
    `CHK("ubox shared en", 8'h30, ubox_count)
    ubox_clr = 2'h3;
    tick(1);
    ubox_clr = 2'h0;
    `CHK("ubox clear", 8'h00, ubox_count)
    go;
    ubox_evt = 2'h1;
    tick(15);
    `CHK("ubox full", 8'h0f, ubox_count)
    tick(1);
    ubox_evt = 2'h0;
    `CHK("ubox wrap", 8'h00, ubox_count)
    `CHK("ubox ovf", 1'b1, ubox_ovf)
    `CHK("pcu ovf local", 1'b0, pcu_ovf)
  endtask : s_ubox
  task automatic s_freeze;
    go;
    freeze_on_ovf = 1'b1;
    cbox_box_en = 2'h1;
    cbox_ctr_en = 8'h01;
    cbox_clr = 8'h01;
    tick(1);
    cbox_clr = 8'h00;
    cev(8'h01, 15);
    `CHK("full", 4'hf, cc(0))
    cev(8'h01, 1);
    `CHK("wrapped", 4'h0, cc(0))
    `CHK("ovf pulse", 2'h1, cbox_ovf)
    `CHK("not yet frozen", 1'b1, glb_en)
    tick(1);
    `CHK("frozen", 1'b0, glb_en)
    `CHK("ovf one cycle", 2'h0, cbox_ovf)
    cev(8'h01, 2);
    `CHK("stopped", 4'h0, cc(0))
  endtask : s_freeze
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  initial
  begin
    {mclk, resetn, glb_en_set, glb_en_clr, freeze_on_ovf, pcu_box_en} = '0;
    {cbox_box_en, cbox_ctr_en, cbox_occ, cbox_evt, cbox_clr} = '0;
    {pcu_ctr_en, pcu_evt, pcu_clr, pcu_code, pcu_match, pcu_mask} = '0;
    {ubox_ctr_en, ubox_evt, ubox_clr} = '0;
    repeat (4) @(posedge mclk);
    #1;
    resetn = 1'b1;
    s_gate;
    s_occ;
    s_pcu;
    s_ubox;
    s_freeze;
    close_out;
  end
  // hang guard
  initial
  begin
    #200us;
    fail_count++;
    close_out;
  end
endmodule : testbench
`default_nettype wire
